//--- design/usbepf_fifo.sv
// Purpose: Small staging FIFO between the serial engine and the DMA port.
// Assumes: One clock, synchronous active-high reset.
// Notes: Flush empties it in one cycle; a push in that cycle is dropped.
`timescale 1ns/1ps
`default_nettype none
module usbepf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_flush,
	// Filling side.
	input wire logic [WIDTH-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	// Draining side.
	output logic [WIDTH-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// The pointers wrap by power of two only, so other depths are refused at elaboration.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
		$error("usbepf_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Full and empty are taken straight from the occupancy count.
	assign o_ready = (count != (AW+1)'(DEPTH));
	assign o_valid = (count != '0);
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	// Storage is written only, never reset.
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	// Head word is held in a register so the port data come from a flop.
	always_ff @(posedge i_clk) begin
		if (i_rst || i_flush) begin
			o_data <= '0;
		end else if (pop && count > (AW+1)'(1)) begin
			o_data <= mem[rd_ptr + AW'(1)];
		end else if (push && (count == '0 || (pop && count == (AW+1)'(1)))) begin
			o_data <= i_data;
		end
	end

	// Pointers and occupancy.
	always_ff @(posedge i_clk) begin
		if (i_rst || i_flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

//--- design/usbepf_pkg.sv
// Purpose: Shared constants and types for the endpoint buffer port control block.
// Assumes: 16-bit register bus, registers at byte offsets.
// Notes: Field positions, offsets and reset values live here; the assertions repeat the field positions as literals.
package usbepf_pkg;
	// Register offsets.
	localparam logic [6:0] ADDR_SIDE_HANDOFF = 7'h2e;
	localparam logic [6:0] ADDR_DMA_SETUP = 7'h30;
	// Handoff register fields.
	localparam int BIT_SIDE_SWAP = 15;
	localparam int BIT_ENGINE_SIDE_CLEAR = 14;
	localparam int BIT_ENGINE_SIDE_BUSY = 13;
	// Setup register fields.
	localparam int BIT_LENGTH_COUNTDOWN = 15;
	localparam int BIT_POINTER_REWIND = 14;
	localparam int BIT_AUTO_CLEAR = 13;
	localparam int BIT_ACCESS_WIDTH = 10;
	localparam int BIT_XACT_ON = 9;
	localparam int BIT_XACT_ZERO = 8;
	localparam int PIPE_LSB = 0;
	// Reset values.
	localparam logic [15:0] RST_SIDE_HANDOFF = 16'h0000;
	localparam logic [15:0] RST_DMA_SETUP = 16'h0000;
	// Pipe codes.
	localparam logic [2:0] PIPE_NONE = 3'h0;
	localparam logic [2:0] PIPE_BAD = 3'h7;
	// Byte steps per DMA read.
	localparam logic [9:0] STEP_8BIT = 10'h001;
	localparam logic [9:0] STEP_16BIT = 10'h002;
	// Staging buffer defaults.
	localparam int FIFO_WIDTH = 16;
	localparam int FIFO_DEPTH = 4;

	// Writable state of the DMA port setup register.
	typedef struct packed {
		logic length_countdown_mode;
		logic auto_clear_mode;
		logic port_access_width;
		logic xact_counter_on;
		logic [2:0] pipe;
	} usbepf_setup_t;

	// One register bus access.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [15:0] wdata;
	} usbepf_bus_t;
endpackage

//--- design/usbepf_port_ctrl.sv
// Purpose: Buffer handoff controls of the CPU port and setup of the DMA port.
// Assumes: Bus and engine signals are synchronous to I_SYS_CLK (20 MHz).
// Notes: Commands leave as one-cycle pulses toward the buffer manager.
// What the document requires of this block and of software
// RULE1: Writing side swap in continuous mode, buffer not full, hands engine buffer to CPU.
// RULE2: A software side swap raises buffer ready for the selected pipe.
// RULE3: Side swap acts only on OUT pipes; control pipe and zero writes ignored.
// RULE4: Writing engine side clear empties engine buffer, hands it over; reads zero.
// RULE5: Engine side clear acts only on IN pipes, never the control pipe.
// RULE6: Software sets NAK and waits for busy zero before engine side clear.
// RULE7: Busy flag shows engine access to selected pipe's buffer; control pipe meaningless.
// RULE8: Countdown mode decrements rx length per read; else hold, clear when all read.
// RULE9: Rewind resets read pointer for OUT, write pointer for IN; reads zero.
// RULE10: Auto clear mode bit enables automatic clearing, read-write, resets zero.
// RULE11: Access width bit selects 8-bit when zero, 16-bit when one.
// RULE12: Transaction counter enable bit switches the counter function off or on.
// RULE13: Writing one to counter clear zeroes the transaction counter.
// RULE14: Pipe select 000 disables port, 001 to 110 pipes one to six, 111 invalid.
// RULE15: Auto clear on an OUT pipe clears the buffer once all data read.
// RULE16: Rewind written with a new pipe select applies to the new pipe.
// RULE17: Software never selects one pipe on both CPU and DMA ports.
// RULE18: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module usbepf_port_ctrl
	import usbepf_pkg::*;
#(
	parameter int DATA_WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int XACT_WIDTH = 16
) (
	// Clock and reset.
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	// Register bus.
	input wire usbepf_bus_t I_BUS,
	output logic [15:0] O_RDATA,
	// CPU port pipe state.
	input wire logic [2:0] I_CPU_PIPE,
	input wire logic I_CPU_PIPE_OUT,
	input wire logic I_CONT_MODE,
	input wire logic I_BUF_FULL,
	input wire logic I_ENGINE_BUSY,
	// CPU port handoff commands.
	output logic O_SIDE_SWAP,
	output logic O_ENGINE_CLEAR,
	output logic O_BUF_READY,
	output logic [2:0] O_BUF_READY_PIPE,
	// DMA port pipe state and commands.
	input wire logic I_DMA_PIPE_OUT,
	output usbepf_setup_t O_SETUP,
	output logic O_DMA_PORT_ON,
	output logic O_REWIND_RD,
	output logic O_REWIND_WR,
	output logic [2:0] O_REWIND_PIPE,
	output logic O_AUTO_CLEAR,
	// Receive length and transaction counting.
	input wire logic I_RX_LEN_LOAD,
	input wire logic [9:0] I_RX_LEN,
	input wire logic I_XACT_DONE,
	output logic [9:0] O_RX_LENGTH,
	output logic [XACT_WIDTH-1:0] O_XACT_COUNT,
	// Engine data into the staging buffer.
	input wire logic [DATA_WIDTH-1:0] I_ENG_DATA,
	input wire logic I_ENG_VALID,
	output logic O_ENG_READY,
	// DMA port data out of the staging buffer.
	output logic [DATA_WIDTH-1:0] O_DMA_DATA,
	output logic O_DMA_VALID,
	input wire logic I_DMA_READ
);
	// The bus is 16 bits wide and the length field is 10 bits, so other widths are refused.
	if (DATA_WIDTH != 16 || XACT_WIDTH < 1 || XACT_WIDTH > 16) begin : g_bad_width
		$error("usbepf_port_ctrl: unsupported width parameters");
	end

	// A pipe code names a real data pipe only in the range one to six.
	function automatic logic pipe_is_data(input logic [2:0] p);
		return (p != PIPE_NONE) && (p != PIPE_BAD);
	endfunction

	usbepf_setup_t setup;
	logic [9:0] rx_length;
	logic [9:0] remaining;
	logic [XACT_WIDTH-1:0] xact_count;
	logic wr_handoff;
	logic wr_setup;
	logic [2:0] next_pipe;
	logic [9:0] step;
	logic dma_pop;
	logic last_read;
	logic rewind_now;
	logic fifo_flush;

	// Register write decode.
	assign wr_handoff = I_BUS.wr && (I_BUS.addr == ADDR_SIDE_HANDOFF);
	assign wr_setup = I_BUS.wr && (I_BUS.addr == ADDR_DMA_SETUP);

	// The pipe the rest of this write acts on, new if the write changes it.
	assign next_pipe = wr_setup ? I_BUS.wdata[PIPE_LSB +: 3] : setup.pipe;

	// Setup register fields; pointer bits and reserved bits are not stored.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			// Each field takes its own bit of the register's reset value.
			setup.length_countdown_mode <= RST_DMA_SETUP[BIT_LENGTH_COUNTDOWN];
			setup.auto_clear_mode <= RST_DMA_SETUP[BIT_AUTO_CLEAR];
			setup.port_access_width <= RST_DMA_SETUP[BIT_ACCESS_WIDTH];
			setup.xact_counter_on <= RST_DMA_SETUP[BIT_XACT_ON];
			setup.pipe <= RST_DMA_SETUP[PIPE_LSB +: 3];
		end else if (wr_setup) begin
			// RULE8: countdown mode select
			setup.length_countdown_mode <= I_BUS.wdata[BIT_LENGTH_COUNTDOWN];
			// RULE10: auto clear enable
			setup.auto_clear_mode <= I_BUS.wdata[BIT_AUTO_CLEAR];
			// RULE11: access width select
			setup.port_access_width <= I_BUS.wdata[BIT_ACCESS_WIDTH];
			// RULE12: counter enable stored
			setup.xact_counter_on <= I_BUS.wdata[BIT_XACT_ON];
			// RULE14: pipe select stored
			setup.pipe <= I_BUS.wdata[PIPE_LSB +: 3];
		end
	end

	// RULE14: port on only for pipes one to six
	assign O_DMA_PORT_ON = pipe_is_data(setup.pipe);
	assign O_SETUP = setup;

	// Handoff commands toward the buffer manager as single-cycle pulses; the ready pipe code is registered every cycle.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_SIDE_SWAP <= 1'b0;
			O_ENGINE_CLEAR <= 1'b0;
			O_BUF_READY <= 1'b0;
			O_BUF_READY_PIPE <= PIPE_NONE;
		end else begin
			// RULE1: swap while not full
			// RULE3: OUT pipes only, ones only
			O_SIDE_SWAP <= wr_handoff && I_BUS.wdata[BIT_SIDE_SWAP] && pipe_is_data(I_CPU_PIPE)
				&& I_CPU_PIPE_OUT && I_CONT_MODE && !I_BUF_FULL;
			// RULE2: ready raised with swap
			O_BUF_READY <= wr_handoff && I_BUS.wdata[BIT_SIDE_SWAP] && pipe_is_data(I_CPU_PIPE)
				&& I_CPU_PIPE_OUT && I_CONT_MODE && !I_BUF_FULL;
			O_BUF_READY_PIPE <= I_CPU_PIPE;
			// RULE4: clear and hand over
			// RULE5: IN pipes only
			O_ENGINE_CLEAR <= wr_handoff && I_BUS.wdata[BIT_ENGINE_SIDE_CLEAR]
				&& pipe_is_data(I_CPU_PIPE) && !I_CPU_PIPE_OUT;
		end
	end

	// RULE9: rewind is a one-shot write
	// RULE16: aimed at the newly selected pipe
	assign rewind_now = wr_setup && I_BUS.wdata[BIT_POINTER_REWIND] && pipe_is_data(next_pipe);

	// Rewind pulses carry the pipe they apply to.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_REWIND_RD <= 1'b0;
			O_REWIND_WR <= 1'b0;
			O_REWIND_PIPE <= PIPE_NONE;
		end else begin
			O_REWIND_RD <= rewind_now && I_DMA_PIPE_OUT;
			O_REWIND_WR <= rewind_now && !I_DMA_PIPE_OUT;
			O_REWIND_PIPE <= next_pipe;
		end
	end

	// Staged words are stale after a rewind or a pipe change, so drop them.
	assign fifo_flush = rewind_now || (wr_setup && next_pipe != setup.pipe);

	// Reads only drain while the port is enabled.
	assign dma_pop = I_DMA_READ && O_DMA_VALID && O_DMA_PORT_ON;

	// RULE11: bytes consumed per read
	assign step = setup.port_access_width ? STEP_16BIT : STEP_8BIT;
	assign last_read = dma_pop && (remaining <= step);

	// Receive length seen by software and the hidden byte tracker behind it.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			rx_length <= '0;
			remaining <= '0;
		end else if (I_RX_LEN_LOAD) begin
			rx_length <= I_RX_LEN;
			remaining <= I_RX_LEN;
		end else if (dma_pop) begin
			remaining <= last_read ? 10'h000 : remaining - step;
			// RULE8: count down or hold then clear
			if (setup.length_countdown_mode) begin
				rx_length <= (rx_length <= step) ? 10'h000 : rx_length - step;
			end else if (last_read) begin
				rx_length <= 10'h000;
			end
		end
	end
	assign O_RX_LENGTH = rx_length;

	// RULE15: automatic clear after last read
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_AUTO_CLEAR <= 1'b0;
		end else begin
			O_AUTO_CLEAR <= last_read && setup.auto_clear_mode && I_DMA_PIPE_OUT;
		end
	end

	// Transaction counter; a clear write wins over a count in the same cycle.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			xact_count <= '0;
		end else if (wr_setup && I_BUS.wdata[BIT_XACT_ZERO]) begin
			// RULE13: clear to zero
			xact_count <= '0;
		end else if (setup.xact_counter_on && I_DMA_PIPE_OUT && I_XACT_DONE) begin
			// RULE12: counts only when on
			xact_count <= xact_count + XACT_WIDTH'(1);
		end
	end
	assign O_XACT_COUNT = xact_count;

	// Register readback, one cycle after the read strobe.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_RDATA <= RST_SIDE_HANDOFF;
		end else if (I_BUS.rd) begin
			O_RDATA <= 16'h0000;
			// RULE18: reserved bits read zero
			if (I_BUS.addr == ADDR_SIDE_HANDOFF) begin
				// RULE7: busy for a data pipe only
				O_RDATA[BIT_ENGINE_SIDE_BUSY] <= I_ENGINE_BUSY && pipe_is_data(I_CPU_PIPE);
			end else if (I_BUS.addr == ADDR_DMA_SETUP) begin
				O_RDATA[BIT_LENGTH_COUNTDOWN] <= setup.length_countdown_mode;
				O_RDATA[BIT_AUTO_CLEAR] <= setup.auto_clear_mode;
				O_RDATA[BIT_ACCESS_WIDTH] <= setup.port_access_width;
				O_RDATA[BIT_XACT_ON] <= setup.xact_counter_on;
				O_RDATA[PIPE_LSB +: 3] <= setup.pipe;
			end
		end
	end

	// Staging buffer between the engine and the DMA port.
	usbepf_fifo #(
		.WIDTH(DATA_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_flush(fifo_flush),
		.i_data(I_ENG_DATA),
		.i_valid(I_ENG_VALID),
		.o_ready(O_ENG_READY),
		.o_data(O_DMA_DATA),
		.o_valid(O_DMA_VALID),
		.i_ready(dma_pop)
	);
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the port control block.
// Assumes: Inputs move on falling edges of a 50 ns clock.
// Notes: Each scenario task judges its own results.
`timescale 1ns/1ps
`default_nettype none
module testbench import usbepf_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	usbepf_bus_t bus = '0;
	logic [2:0] cp = 3'h0;
	logic co = 1'b0, cont = 1'b0, full = 1'b0, busy = 1'b0, dout = 1'b0, ld = 1'b0, xd = 1'b0, ev = 1'b0;
	logic go = 1'b0, slow = 1'b0;
	logic [9:0] lin = 10'h000;
	logic [15:0] ed = 16'h0000;
	logic [15:0] rdata, sum, pops, xc, dd;
	logic swap, eclr, brdy, rwr, rww, pon, erdy, dv, drd, acl;
	logic [2:0] brp, rwp;
	logic [9:0] rxl;
	usbepf_setup_t setup;
	int n_errors = 0;
	int compares = 0;
	usbepf_port_ctrl u_usbepf_port_ctrl (.I_SYS_CLK(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata),
		.I_CPU_PIPE(cp), .I_CPU_PIPE_OUT(co), .I_CONT_MODE(cont), .I_BUF_FULL(full), .I_ENGINE_BUSY(busy),
		.O_SIDE_SWAP(swap), .O_ENGINE_CLEAR(eclr), .O_BUF_READY(brdy), .O_BUF_READY_PIPE(brp),
		.I_DMA_PIPE_OUT(dout), .O_SETUP(setup), .O_DMA_PORT_ON(pon), .O_REWIND_RD(rwr), .O_REWIND_WR(rww),
		.O_REWIND_PIPE(rwp), .O_AUTO_CLEAR(acl), .I_RX_LEN_LOAD(ld), .I_RX_LEN(lin), .I_XACT_DONE(xd),
		.O_RX_LENGTH(rxl), .O_XACT_COUNT(xc), .I_ENG_DATA(ed), .I_ENG_VALID(ev), .O_ENG_READY(erdy),
		.O_DMA_DATA(dd), .O_DMA_VALID(dv), .I_DMA_READ(drd));
	usbepf_dma_model u_usbepf_dma_model (.i_clk(clk), .i_go(go), .i_slow(slow), .i_valid(dv), .i_data(dd),
		.o_read(drd), .o_sum(sum), .o_pops(pops));
	// Free-running clock.
	always #25 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge clk);
		bus = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		bus = '0;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(negedge clk);
		bus = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge clk);
		bus = '0;
		d = rdata;
	endtask
	task automatic pulse(input int k);
		repeat (k) begin
			@(negedge clk);
			xd = 1'b1;
			@(negedge clk);
			xd = 1'b0;
		end
	endtask
	task automatic wait_pops(input logic [15:0] k);
		for (int t = 0; t < 40 && pops !== k; t++) @(negedge clk);
		chk(pops, k);
	endtask
	// Load a length, fill the buffer until it refuses, then start a slow drain.
	task automatic stream(input logic [15:0] c, input logic [9:0] l);
		logic [7:0] n;
		n = 8'h00;
		wr(ADDR_DMA_SETUP, c);
		@(negedge clk);
		lin = l;
		ld = 1'b1;
		repeat (6) begin
			@(negedge clk);
			ld = 1'b0;
			ed = {8'h0a, n};
			ev = erdy;
			n = n + {7'h00, erdy};
		end
		chk({8'h00, n}, 16'h0004);
		chk(erdy, 0);
		// The model samples its controls on this same falling edge, so they change after it.
		slow <= 1'b1;
		go <= 1'b1;
		wait_pops(16'h0001);
	endtask
	task automatic t_regs();
		logic [15:0] d;
		rd(ADDR_SIDE_HANDOFF, d);
		chk(d, RST_SIDE_HANDOFF);
		rd(ADDR_DMA_SETUP, d);
		chk(d, RST_DMA_SETUP);
		rd(7'h32, d);
		chk(d, 16'h0000);
		wr(ADDR_DMA_SETUP, 16'hffff);
		chk(pon, 0);
		chk(setup, 16'h007f);
		rd(ADDR_DMA_SETUP, d);
		chk(d, 16'ha607);
		for (int p = 0; p < 7; p++) begin
			wr(ADDR_DMA_SETUP, 16'(p));
			chk(pon, p != 0);
		end
		$display("test regs done");
	endtask
	task automatic t_swap();
		logic [5:0] cfg [5] = '{6'h06, 6'h12, 6'h17, 6'h14, 6'h3e};
		{cp, co, cont, full} = 6'h16;
		wr(ADDR_SIDE_HANDOFF, 16'h8000);
		chk({swap, brdy, brp}, 5'b11010);
		wr(ADDR_SIDE_HANDOFF, 16'h0000);
		chk(swap, 0);
		foreach (cfg[i]) begin
			{cp, co, cont, full} = cfg[i];
			wr(ADDR_SIDE_HANDOFF, 16'h8000);
			chk(swap, 0);
		end
		$display("test swap done");
	endtask
	task automatic t_clear();
		logic [15:0] d;
		{cp, co, busy} = 5'b01101;
		rd(ADDR_SIDE_HANDOFF, d);
		chk(d, 16'h2000);
		busy = 1'b0;
		rd(ADDR_SIDE_HANDOFF, d);
		chk(d, 16'h0000);
		wr(ADDR_SIDE_HANDOFF, 16'h4000);
		chk(eclr, 1);
		rd(ADDR_SIDE_HANDOFF, d);
		chk(d, 16'h0000);
		co = 1'b1;
		wr(ADDR_SIDE_HANDOFF, 16'h4000);
		chk(eclr, 0);
		$display("test clear done");
	endtask
	task automatic t_rewind();
		dout = 1'b1;
		wr(ADDR_DMA_SETUP, 16'h4002);
		chk({rwr, rww, rwp}, 5'b10010);
		dout = 1'b0;
		wr(ADDR_DMA_SETUP, 16'h4005);
		chk({rwr, rww, rwp}, 5'b01101);
		wr(ADDR_DMA_SETUP, 16'h0005);
		chk({rwr, rww}, 0);
		$display("test rewind done");
	endtask
	task automatic t_xact();
		dout = 1'b1;
		wr(ADDR_DMA_SETUP, 16'h0201);
		pulse(3);
		chk(xc, 3);
		wr(ADDR_DMA_SETUP, 16'h0301);
		chk(xc, 0);
		wr(ADDR_DMA_SETUP, 16'h0001);
		pulse(2);
		chk(xc, 0);
		$display("test xact done");
	endtask
	task automatic t_count();
		stream(16'ha401, 10'h008);
		chk(rxl, 6);
		wait_pops(16'h0004);
		chk(acl, 1);
		chk(rxl, 0);
		chk(sum, 16'h2806);
		go <= 1'b0;
		$display("test count done");
	endtask
	task automatic t_hold();
		stream(16'h0001, 10'h004);
		chk(rxl, 4);
		wait_pops(16'h0004);
		chk(rxl, 0);
		chk(dv, 0);
		chk(acl, 0);
		go <= 1'b0;
		$display("test hold done");
	endtask
	task automatic wrap_up();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Main sequence after six cycles of reset.
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_swap();
		t_clear();
		t_rewind();
		t_xact();
		t_count();
		t_hold();
		wrap_up();
	end
	// Watchdog: the tests need some 110 cycles, so 2000 means a hang.
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire

//--- sim/usbepf_dma_model.sv
// Purpose: DMA controller model that drains the port.
// Assumes: Strobe moves on falling edges, pops land on rising ones.
// Notes: Slow mode reads every other cycle to stall the drain.
`timescale 1ns/1ps
`default_nettype none
module usbepf_dma_model (
	// Control from the bench.
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_slow,
	// Port side.
	input wire logic i_valid,
	input wire logic [15:0] i_data,
	output logic o_read,
	output logic [15:0] o_sum,
	output logic [15:0] o_pops
);
	logic ph;
	// Read strobe, idle whenever the bench stops the model.
	always @(negedge i_clk) begin
		ph <= i_go ? !ph : 1'b0;
		o_read <= i_go && (!i_slow || ph);
	end
	always @(posedge i_clk) begin
		if (!i_go) begin
			o_sum <= 16'h0000;
			o_pops <= 16'h0000;
		end else if (o_read && i_valid) begin
			o_sum <= o_sum + i_data;
			o_pops <= o_pops + 16'h0001;
		end
	end
endmodule
`default_nettype wire

//--- sim/usbepf_port_ctrl_sva.sv
// Purpose: Assertions on the port control outputs.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module usbepf_port_ctrl_chk import usbepf_pkg::*; #(
	parameter int XACT_WIDTH = 16
) (
	// Clock, reset and bus.
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire usbepf_bus_t I_BUS,
	input wire logic [15:0] O_RDATA,
	// CPU port.
	input wire logic [2:0] I_CPU_PIPE,
	input wire logic I_CPU_PIPE_OUT,
	input wire logic I_CONT_MODE,
	input wire logic I_BUF_FULL,
	input wire logic I_ENGINE_BUSY,
	input wire logic O_SIDE_SWAP,
	input wire logic O_ENGINE_CLEAR,
	input wire logic O_BUF_READY,
	input wire logic [2:0] O_BUF_READY_PIPE,
	// DMA port.
	input wire logic I_DMA_PIPE_OUT,
	input wire usbepf_setup_t O_SETUP,
	input wire logic O_REWIND_RD,
	input wire logic O_REWIND_WR,
	input wire logic [2:0] O_REWIND_PIPE,
	input wire logic [XACT_WIDTH-1:0] O_XACT_COUNT
);
	logic wr_h;
	logic wr_s;
	logic ok;
	// Decoded strobes keep each property short.
	assign wr_h = I_BUS.wr && I_BUS.addr == ADDR_SIDE_HANDOFF;
	assign wr_s = I_BUS.wr && I_BUS.addr == ADDR_DMA_SETUP;
	assign ok = I_CPU_PIPE != PIPE_NONE && I_CPU_PIPE != PIPE_BAD;
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	swap_on_write_a: assert property (wr_h && I_BUS.wdata[15] && ok && I_CPU_PIPE_OUT && I_CONT_MODE
		&& !I_BUF_FULL |=> O_SIDE_SWAP) else $error("side swap missing");
	ready_with_swap_a: assert property (O_SIDE_SWAP |-> O_BUF_READY
		&& O_BUF_READY_PIPE == $past(I_CPU_PIPE)) else $error("buffer ready wrong");
	swap_gated_a: assert property (O_SIDE_SWAP |-> $past(wr_h && I_BUS.wdata[15] && ok && I_CPU_PIPE_OUT))
		else $error("side swap unasked");
	clear_gated_a: assert property (O_ENGINE_CLEAR |-> $past(wr_h && I_BUS.wdata[14] && ok && !I_CPU_PIPE_OUT))
		else $error("engine clear unasked");
	busy_read_a: assert property (I_BUS.rd && I_BUS.addr == ADDR_SIDE_HANDOFF |=>
		O_RDATA == {2'b00, $past(I_ENGINE_BUSY && ok), 13'h0000}) else $error("busy readback wrong");
	setup_read_a: assert property (I_BUS.rd && I_BUS.addr == ADDR_DMA_SETUP |=> O_RDATA ==
		{$past(O_SETUP.length_countdown_mode), 1'b0, $past(O_SETUP.auto_clear_mode), 2'b00,
		$past(O_SETUP.port_access_width), $past(O_SETUP.xact_counter_on), 6'h00, $past(O_SETUP.pipe)})
		else $error("setup readback wrong");
	rewind_dir_a: assert property (wr_s && I_BUS.wdata[14] && I_BUS.wdata[2:0] inside {[3'h1:3'h6]} |=>
		O_REWIND_RD == $past(I_DMA_PIPE_OUT) && O_REWIND_WR == !$past(I_DMA_PIPE_OUT)
		&& O_REWIND_PIPE == $past(I_BUS.wdata[2:0])) else $error("rewind wrong");
	count_zero_a: assert property (wr_s && I_BUS.wdata[8] |=> O_XACT_COUNT == '0)
		else $error("counter not cleared");
endmodule
bind usbepf_port_ctrl usbepf_port_ctrl_chk #(.XACT_WIDTH(XACT_WIDTH)) u_chk (.I_SYS_CLK, .I_RST, .I_BUS,
	.O_RDATA, .I_CPU_PIPE, .I_CPU_PIPE_OUT, .I_CONT_MODE, .I_BUF_FULL, .I_ENGINE_BUSY, .O_SIDE_SWAP,
	.O_ENGINE_CLEAR, .O_BUF_READY, .O_BUF_READY_PIPE, .I_DMA_PIPE_OUT, .O_SETUP, .O_REWIND_RD,
	.O_REWIND_WR, .O_REWIND_PIPE, .O_XACT_COUNT);
`default_nettype wire
